// >>> rtl/ewt_consts.svh
`ifndef EWT_CONSTS_SVH
`define EWT_CONSTS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define EWT_CNT_W        16
`define EWT_DIV_W        8

// ****************************************************************
// Start / edge select field encodings
// ****************************************************************
`define EWT_START_STOP   2'h0
`define EWT_START_CMD    2'h1
`define EWT_START_RISE   2'h2
`define EWT_START_FALL   2'h3

// ****************************************************************
// Mode select encodings
// ****************************************************************
`define EWT_MODE_EVENT   2'h0
`define EWT_MODE_WINDOW  2'h1
`define EWT_MODE_PULSE   2'h2

// ****************************************************************
// Source clock divider limits (tick every limit+1 cycles)
// ****************************************************************
`define EWT_DIV_LIM_0    8'h7f
`define EWT_DIV_LIM_1    8'h07
`define EWT_DIV_LIM_2    8'h01
`define EWT_DIV_LIM_3    8'h00

// ****************************************************************
// Reset values and fixed counts
// ****************************************************************
`define EWT_CNT_ZERO     16'h0000
`define EWT_CNT_ONE      16'h0001
`define EWT_DIV_ZERO     8'h00
`define EWT_DIV_ONE      8'h01
`define EWT_CAP_MODE_SGL 1'b1

`endif

// >>> rtl/ewt_pkg.sv
package ewt_pkg;

  // ****************************************************************
  // Mode and measurement sequence types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_EVENT  = 2'h0,
    MODE_WINDOW = 2'h1,
    MODE_PULSE  = 2'h2,
    MODE_SPARE  = 2'h3
  } ewt_mode_type;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_FIRST  = 4'h2,
    ST_SECOND = 4'h4,
    ST_HOLD   = 4'h8
  } ewt_pwm_state_type;

  // ****************************************************************
  // Register state of the synchroniser and of the timer
  // ****************************************************************
  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
  } ewt_sync_type;

  typedef struct packed {
    logic [15:0]       cnt;
    logic [15:0]       cap;
    logic              irq;
    ewt_pwm_state_type fsm;
    logic [7:0]        div;
    logic [1:0]        start;
  } ewt_state_type;

endpackage

// >>> rtl/ewt_edge_sync.sv
`timescale 1ns/10ps

// Two-flop synchroniser for the timer pin, plus edge detection
module ewt_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous pin
  input  wire logic pin_async,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  ewt_pkg::ewt_sync_type sync_reg;
  ewt_pkg::ewt_sync_type sync_next;

  // ****************************************************************
  // Next state: edges look only at the second and third flops
  // ****************************************************************
  always_comb begin
    sync_next        = sync_reg;
    sync_next.meta   = pin_async;
    sync_next.stable = sync_reg.meta;
    sync_next.last   = sync_reg.stable;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Edge pulses last exactly one cycle
  assign level = sync_reg.stable;
  assign rise  = sync_reg.stable & ~sync_reg.last;
  assign fall  = ~sync_reg.stable & sync_reg.last;

endmodule

// >>> rtl/ewt_timer.sv
`timescale 1ns/10ps
`include "ewt_consts.svh"

module ewt_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // External pulse source
  input  wire logic        timer_input_pin,
  // Control fields
  input  wire logic [1:0]  start_edge_select,
  input  wire logic        start_edge_write,
  input  wire logic [1:0]  mode_select,
  input  wire logic [1:0]  source_clock_select,
  input  wire logic        window_low_active,
  input  wire logic        capture_edge_mode,
  input  wire logic        auto_capture_enable,
  input  wire logic        stop_mode_entry,
  input  wire logic [15:0] compare_period_reg,
  // Status and data
  output logic [1:0]       start_edge_status,
  output logic [15:0]      count_value,
  output logic [15:0]      capture_reg,
  output logic [7:0]       capture_reg_low_byte,
  output logic [7:0]       capture_reg_high_byte,
  output logic             timer_match_irq
);

  ewt_pkg::ewt_state_type cur_reg;
  ewt_pkg::ewt_state_type cur_next;

  logic                   pin_level;
  logic                   pin_rise;
  logic                   pin_fall;
  logic                   running;
  logic                   falling_sel;
  logic                   act_edge;
  logic                   opp_edge;
  logic [7:0]             div_limit;
  logic                   tick;
  logic                   gate;
  logic                   cnt_match;
  ewt_pkg::ewt_mode_type  mode;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  ewt_edge_sync u_sync (
    .clk       (clk),
    .rst       (rst),
    .pin_async (timer_input_pin),
    .level     (pin_level),
    .rise      (pin_rise),
    .fall      (pin_fall)
  );

  // ****************************************************************
  // Decode of control and edges
  // ****************************************************************
  // Command-start code counts rising edges, like the rising code
  assign mode        = ewt_pkg::ewt_mode_type'(mode_select);
  assign running     = cur_reg.start != `EWT_START_STOP;
  assign falling_sel = cur_reg.start == `EWT_START_FALL;
  assign act_edge    = running & (falling_sel ? pin_fall : pin_rise);
  assign opp_edge    = running & (falling_sel ? pin_rise : pin_fall);
  assign cnt_match   = cur_reg.cnt == compare_period_reg;
  // Gate is the pin level or its inverse, per polarity
  assign gate        = window_low_active ? ~pin_level : pin_level;

  // Source clock rate select
  always_comb begin
    case (source_clock_select)
      2'h0:    div_limit = `EWT_DIV_LIM_0;
      2'h1:    div_limit = `EWT_DIV_LIM_1;
      2'h2:    div_limit = `EWT_DIV_LIM_2;
      default: div_limit = `EWT_DIV_LIM_3;
    endcase
  end

  // One-cycle enable; divider runs only while started
  assign tick = running & (cur_reg.div == div_limit);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    cur_next     = cur_reg;
    cur_next.irq = 1'b0;
    // Start field write, stop entry wins over a same-cycle write
    if (start_edge_write) begin
      cur_next.start = start_edge_select;
    end
    if (stop_mode_entry) begin
      cur_next.start = `EWT_START_STOP;
    end
    // Divider restarts from zero on each start
    if (!running || tick) begin
      cur_next.div = `EWT_DIV_ZERO;
    end else begin
      cur_next.div = cur_reg.div + `EWT_DIV_ONE;
    end
    if (!running) begin
      // Stopped: counter cleared, capture value kept
      cur_next.cnt = `EWT_CNT_ZERO;
      cur_next.fsm = ewt_pkg::ST_IDLE;
    end else begin
      case (mode)
        ewt_pkg::MODE_EVENT: begin
          if (act_edge) begin
            cur_next.cnt = cur_reg.cnt + `EWT_CNT_ONE;
          end else if (opp_edge && cnt_match) begin
            cur_next.irq = 1'b1;
            cur_next.cnt = `EWT_CNT_ZERO;
          end
          // Pin edge is this mode's source clock
          if (auto_capture_enable && act_edge) begin
            cur_next.cap = cur_reg.cnt;
          end
        end
        ewt_pkg::MODE_WINDOW: begin
          if (tick && gate) begin
            if (cnt_match) begin
              cur_next.irq = 1'b1;
              cur_next.cnt = `EWT_CNT_ZERO;
            end else begin
              cur_next.cnt = cur_reg.cnt + `EWT_CNT_ONE;
            end
          end
          if (auto_capture_enable && tick) begin
            cur_next.cap = cur_reg.cnt;
          end
        end
        ewt_pkg::MODE_PULSE: begin
          case (cur_reg.fsm)
            ewt_pkg::ST_IDLE: begin
              if (act_edge) begin
                cur_next.cnt = `EWT_CNT_ZERO;
                cur_next.fsm = ewt_pkg::ST_FIRST;
              end
            end
            ewt_pkg::ST_FIRST: begin
              if (opp_edge) begin
                cur_next.cap = cur_reg.cnt;
                cur_next.irq = 1'b1;
                if (capture_edge_mode == `EWT_CAP_MODE_SGL) begin
                  cur_next.cnt = `EWT_CNT_ONE;
                  cur_next.fsm = ewt_pkg::ST_HOLD;
                end else begin
                  cur_next.cnt = cur_reg.cnt + `EWT_CNT_ONE;
                  cur_next.fsm = ewt_pkg::ST_SECOND;
                end
              end else if (tick) begin
                cur_next.cnt = cur_reg.cnt + `EWT_CNT_ONE;
              end
            end
            ewt_pkg::ST_SECOND: begin
              if (act_edge) begin
                cur_next.cap = cur_reg.cnt;
                cur_next.irq = 1'b1;
                cur_next.cnt = `EWT_CNT_ZERO;
                cur_next.fsm = ewt_pkg::ST_FIRST;
              end else if (tick) begin
                cur_next.cnt = cur_reg.cnt + `EWT_CNT_ONE;
              end
            end
            ewt_pkg::ST_HOLD: begin
              // Count resumes from one, so later widths read one high
              if (act_edge) begin
                cur_next.fsm = ewt_pkg::ST_FIRST;
              end
            end
            default: begin
              cur_next.fsm = ewt_pkg::ST_IDLE;
            end
          endcase
        end
        default: begin
          cur_next.cnt = cur_reg.cnt;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg       <= '0;
      cur_reg.fsm   <= ewt_pkg::ST_IDLE;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ****************************************************************
  // Outputs, all from flops
  // ****************************************************************
  assign start_edge_status     = cur_reg.start;
  assign count_value           = cur_reg.cnt;
  assign capture_reg           = cur_reg.cap;
  // Byte views are live slices of one register; nothing latches a split read
  assign capture_reg_low_byte  = cur_reg.cap[7:0];
  assign capture_reg_high_byte = cur_reg.cap[15:8];
  assign timer_match_irq       = cur_reg.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Stop entry halts the timer on the next edge
  a_stop_forces_idle: assert property (
    @(posedge clk) disable iff (rst)
    stop_mode_entry |=> start_edge_status == `EWT_START_STOP)
    else $error("stop entry did not clear start field");

  // Event counting steps by one on the active edge
  a_event_count_step: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ewt_pkg::MODE_EVENT && act_edge && !stop_mode_entry)
    |=> count_value == $past(count_value) + `EWT_CNT_ONE)
    else $error("event count did not step");

  // Match on opposite edge gives one irq pulse and a clear
  a_event_match_clear: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ewt_pkg::MODE_EVENT && opp_edge && cnt_match)
    |=> timer_match_irq && count_value == `EWT_CNT_ZERO ##1 !timer_match_irq)
    else $error("event match did not interrupt and clear");

  // Active edge never raises the interrupt in event mode
  a_event_no_irq_act: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ewt_pkg::MODE_EVENT && act_edge) |=> !timer_match_irq)
    else $error("interrupt on counting edge");

  // Closed window freezes the counter
  a_window_gate_hold: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ewt_pkg::MODE_WINDOW && running && !stop_mode_entry && !gate)
    |=> count_value == $past(count_value))
    else $error("window counted while closed");

  // Window match clears and interrupts
  a_window_match_irq: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ewt_pkg::MODE_WINDOW && tick && gate && cnt_match)
    |=> timer_match_irq && count_value == `EWT_CNT_ZERO)
    else $error("window match missed");

  // Auto-capture copies the running count on a source tick
  a_auto_capture_copy: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ewt_pkg::MODE_WINDOW && auto_capture_enable && tick)
    |=> capture_reg == $past(count_value))
    else $error("auto-capture missed a tick");

  // Single-edge hold keeps the count at one
  a_single_hold_one: assert property (
    @(posedge clk) disable iff (rst)
    (running && cur_reg.fsm == ewt_pkg::ST_HOLD) |-> count_value == 16'h0001)
    else $error("hold state count not one");

  // Double-edge second capture clears counter
  a_double_second_cap: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ewt_pkg::MODE_PULSE && !stop_mode_entry
     && cur_reg.fsm == ewt_pkg::ST_SECOND && act_edge)
    |=> capture_reg == $past(count_value) && count_value == `EWT_CNT_ZERO
        && timer_match_irq)
    else $error("double-edge trigger capture wrong");

endmodule

// >>> bench/ewt_pulse_src.sv
`timescale 1ns/10ps

// ****************************************************************
// Pulse source facing the timer pin
// ****************************************************************
// Behavioural stand-in for the external device. It drives the pin
// just after a rising edge and holds each level a whole number of
// cycles, never fewer than MIN_W.
module ewt_pulse_src #(
  parameter int MIN_W = 4
) (
  // Clock
  input  wire logic clk,
  // Driven pin level
  output logic      pin
);
  localparam time DLY = 2;

  // Pin starts low, a defined level before any traffic
  initial pin = 1'b0;

  // One level for w cycles; short requests are stretched
  task automatic hold_level(input logic lvl, input int w);
    int n;
    n = (w < MIN_W) ? MIN_W : w;
    pin = lvl;
    repeat (n) @(posedge clk);
    #DLY;
  endtask

  // Train of cnt pulses, first level then its inverse
  task automatic pulses(input logic lvl, input int hw, input int lw,
                        input int cnt);
    for (int i = 0; i < cnt; i++) begin
      hold_level(lvl, hw);
      hold_level(!lvl, lw);
    end
  endtask
endmodule

// >>> bench/event_window_pulse_width_timer_tb.sv
`timescale 1ns/10ps
`include "ewt_consts.svh"

module event_window_pulse_width_timer_tb;
  localparam time DLY = 2;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pin;
  logic [1:0]  start_edge_select = 2'h0;
  logic        start_edge_write = 1'b0;
  logic [1:0]  mode_select = 2'h0;
  logic [1:0]  source_clock_select = 2'h3;
  logic        window_low_active = 1'b0;
  logic        capture_edge_mode = 1'b0;
  logic        auto_capture_enable = 1'b0;
  logic        stop_mode_entry = 1'b0;
  logic [15:0] compare_period_reg = 16'hffff;
  logic [1:0]  start_edge_status;
  logic [15:0] count_value;
  logic [15:0] capture_reg;
  logic [7:0]  cap_lo;
  logic [7:0]  cap_hi;
  logic        timer_match_irq;
  logic [15:0] a1, a2, p1, s1, s2;
  int          n_fail = 0;
  int          compares = 0;
  int          n_irq = 0;

  // Free-running clock
  always #20 clk = ~clk;

  ewt_pulse_src src (.clk(clk), .pin(pin));

  ewt_timer dut (
    .clk(clk), .rst(rst), .timer_input_pin(pin),
    .start_edge_select(start_edge_select),
    .start_edge_write(start_edge_write), .mode_select(mode_select),
    .source_clock_select(source_clock_select),
    .window_low_active(window_low_active),
    .capture_edge_mode(capture_edge_mode),
    .auto_capture_enable(auto_capture_enable),
    .stop_mode_entry(stop_mode_entry),
    .compare_period_reg(compare_period_reg),
    .start_edge_status(start_edge_status), .count_value(count_value),
    .capture_reg(capture_reg), .capture_reg_low_byte(cap_lo),
    .capture_reg_high_byte(cap_hi), .timer_match_irq(timer_match_irq));

  // Interrupt pulses tallied; only the count is compared
  always @(posedge clk) begin
    if (timer_match_irq === 1'b1) n_irq++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #DLY;
  endtask

  task automatic check16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Range compare; an unknown value never satisfies it
  task automatic check_range(input string what, input int lo, input int hi,
                             input logic [15:0] got);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask

  task automatic start(input logic [1:0] s);
    start_edge_select = s;
    start_edge_write = 1'b1;
    cyc(1);
    start_edge_write = 1'b0;
    cyc(1);
  endtask

  // Settings only change while stopped
  task automatic setup(input logic [1:0] m, input logic [1:0] ck,
                       input logic lowa, input logic cm, input logic ac,
                       input logic [15:0] cmp);
    start(`EWT_START_STOP);
    mode_select = m;
    source_clock_select = ck;
    window_low_active = lowa;
    capture_edge_mode = cm;
    auto_capture_enable = ac;
    compare_period_reg = cmp;
    n_irq = 0;
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, n_fail);
  endtask

  task automatic finish_test();
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, well past the expected run length
  initial begin
    #(40 * 30000);
    n_fail++;
    finish_test();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    cyc(5);
    rst = 1'b0;
    check16("reset status", 16'h0000, 16'(start_edge_status));
    check16("reset count", 16'h0000, count_value);
    // Event mode, rising edges, compare 3, auto-capture on
    setup(2'h0, 2'h3, 1'b0, 1'b0, 1'b1, 16'h0003);
    start(`EWT_START_RISE);
    check16("status rise", 16'h0002, 16'(start_edge_status));
    src.hold_level(1'b1, 8);
    check16("event count 1", 16'h0001, count_value);
    src.pulses(1'b0, 8, 8, 2);
    check16("event count 3", 16'h0003, count_value);
    check16("no irq on count edge", 16'h0000, 16'(n_irq));
    check16("auto capture", 16'h0002, capture_reg);
    check16("cap low byte", 16'h0002, 16'(cap_lo));
    check16("cap high byte", 16'h0000, 16'(cap_hi));
    src.hold_level(1'b0, 8);
    check16("irq on opposite edge", 16'h0001, 16'(n_irq));
    check16("event cleared", 16'h0000, count_value);
    src.hold_level(1'b1, 8);
    check16("event resumes", 16'h0001, count_value);
    src.hold_level(1'b0, 8);
    // Falling edges counted instead
    setup(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 16'h0003);
    start(`EWT_START_FALL);
    src.hold_level(1'b1, 8);
    check16("fall no count on rise", 16'h0000, count_value);
    src.hold_level(1'b0, 8);
    check16("fall count", 16'h0001, count_value);
    // Stop entry clears the field and beats a write
    stop_mode_entry = 1'b1;
    start_edge_select = `EWT_START_RISE;
    start_edge_write = 1'b1;
    cyc(1);
    stop_mode_entry = 1'b0;
    start_edge_write = 1'b0;
    cyc(1);
    check16("stop forces field", 16'h0000, 16'(start_edge_status));
    // Spare mode code leaves the cleared counter alone
    setup(2'h3, 2'h3, 1'b0, 1'b0, 1'b0, 16'h0003);
    start(`EWT_START_CMD);
    src.pulses(1'b1, 8, 8, 1);
    check16("spare mode holds", 16'h0000, count_value);
    end_test("event");

    // Window mode, each source clock rate, slow window
    for (int k = 0; k < 4; k++) begin
      setup(2'h1, 2'(k), 1'b0, 1'b0, 1'b0, 16'hffff);
      start(`EWT_START_CMD);
      src.hold_level(1'b0, 16);
      check16("window closed", 16'h0000, count_value);
      src.hold_level(1'b1, 512);
      src.hold_level(1'b0, 16);
      a1 = 16'(512 >> (k == 0 ? 7 : k == 1 ? 3 : k == 2 ? 1 : 0));
      check_range("window count", a1 - 2, a1 + 2, count_value);
    end
    // Negative polarity
    setup(2'h1, 2'h3, 1'b1, 1'b0, 1'b0, 16'hffff);
    // Pin parked high first, else the window opens at start
    src.hold_level(1'b1, 8);
    start(`EWT_START_CMD);
    src.hold_level(1'b1, 64);
    check16("low window idle", 16'h0000, count_value);
    src.hold_level(1'b0, 64);
    check_range("low window count", 62, 66, count_value);
    // Match at 3 wraps every four ticks
    setup(2'h1, 2'h3, 1'b0, 1'b0, 1'b1, 16'h0003);
    start(`EWT_START_CMD);
    src.hold_level(1'b1, 40);
    src.hold_level(1'b0, 8);
    check_range("window irqs", 9, 11, 16'(n_irq));
    check_range("window wrapped", 0, 3, count_value);
    // Forty open ticks end on a clear, so the copy reads zero
    check16("window auto capture", 16'h0000, capture_reg);
    end_test("window");

    // Pulse mode, double-edge, high-first period
    setup(2'h2, 2'h3, 1'b0, 1'b0, 1'b0, 16'hffff);
    start(`EWT_START_RISE);
    src.pulses(1'b1, 20, 30, 1);
    src.hold_level(1'b1, 20);
    src.hold_level(1'b0, 30);
    a1 = capture_reg;
    src.hold_level(1'b1, 20);
    p1 = capture_reg;
    src.hold_level(1'b0, 30);
    a2 = capture_reg;
    check_range("high width", 19, 21, a1);
    check16("period minus width", 16'h001e, p1 - a1);
    check16("width repeats", a1, a2);
    check16("irq per capture", 16'h0005, 16'(n_irq));
    end_test("double");

    // Pulse mode, single-edge, counter held at one
    setup(2'h2, 2'h3, 1'b0, 1'b1, 1'b0, 16'hffff);
    start(`EWT_START_RISE);
    src.pulses(1'b1, 20, 30, 1);
    s1 = capture_reg;
    check16("held at one", 16'h0001, count_value);
    src.pulses(1'b1, 20, 30, 1);
    s2 = capture_reg;
    check16("second is one more", s1 + 16'h0001, s2);
    src.pulses(1'b1, 20, 30, 1);
    check16("restart repeats", s2, capture_reg);
    check16("single irqs", 16'h0003, 16'(n_irq));
    // Low width with falling trigger
    setup(2'h2, 2'h3, 1'b0, 1'b1, 1'b0, 16'hffff);
    start(`EWT_START_FALL);
    src.hold_level(1'b1, 10);
    src.pulses(1'b0, 30, 20, 2);
    check_range("low width", 29, 32, capture_reg);
    end_test("single");
    finish_test();
  end
endmodule
